/* File: verilog/dea_pkg.sv */
package dea_pkg;
   // Register indices on the plain register port (byte address = index)
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_KEY = 4'h1;
   localparam logic [3:0] ADDR_DATA = 4'h2;
   localparam logic [3:0] ADDR_ADDR_LOW = 4'h3;
   localparam logic [3:0] ADDR_ADDR_HIGH = 4'h4;
   localparam logic [3:0] ADDR_PTR_UPPER = 4'h5;
   localparam logic [3:0] ADDR_PTR_HIGH = 4'h6;
   localparam logic [3:0] ADDR_PTR_LOW = 4'h7;
   localparam logic [3:0] ADDR_LATCH = 4'h8;
   localparam logic [3:0] ADDR_FLAGS_TWO = 4'h9;
   localparam logic [3:0] ADDR_ENABLES_TWO = 4'ha;
   localparam logic [3:0] ADDR_PRIORITY_TWO = 4'hb;
   localparam logic [3:0] ADDR_INT_MAIN = 4'hc;

   // Control register bit positions
   localparam int BIT_MEM_SEL = 7;
   localparam int BIT_CFG_SEL = 6;
   localparam int BIT_ROW_ERASE = 4;
   localparam int BIT_ABORT = 3;
   localparam int BIT_PERMIT = 2;
   localparam int BIT_WRITE_GO = 1;
   localparam int BIT_READ_GO = 0;
   // Write complete flag in the peripheral flag/enable registers
   localparam int BIT_DONE_FLAG = 4;

   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;
   localparam logic [7:0] UNUSED_UPPER_MASK = 8'h3f;

   // Self-timed write time
   localparam int CLK_PERIOD_NS = 50;
   localparam int WRITE_TIME_US = 4000;
   localparam int WRITE_CYCLES = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      DEA_KEY_IDLE = 2'b00,
      DEA_KEY_FIRST = 2'b01,
      DEA_KEY_ARMED = 2'b10
   } dea_key_state_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dea_bus_req_t;
endpackage

/* File: verilog/dea_access_ctrl.sv */
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dea_access_ctrl #(
   parameter int WRITE_CYCLES = dea_pkg::WRITE_CYCLES,
   parameter int DEPTH = 1024
) (
   input wire logic ref_clk, // Core clock
   input wire logic reset, // Synchronous reset, active high
   input wire dea_pkg::dea_bus_req_t bus_req, // Register port request
   output logic [7:0] rdata, // Read data, cycle after read strobe
   output logic irq, // Level interrupt
   output logic flash_op_start, // Pulse: flash erase or write begins
   output logic flash_op_erase, // Flash operation is a row erase
   output logic cfg_op_start, // Pulse: configuration write begins
   output logic [21:0] table_pointer // Program memory table pointer
);
   initial begin
      if (WRITE_CYCLES < 1 || DEPTH != 1024) begin
         $error("dea_access_ctrl: unsupported parameters");
      end
   end

   localparam int CW = $clog2(WRITE_CYCLES + 1);

   logic [7:0] mem [0:DEPTH-1];
   logic mem_sel, cfg_sel, row_erase, abort_flag, permit, write_go;
   logic [7:0] nv_data_byte, nv_address_low, nv_address_high;
   logic [7:0] ptr_upper, ptr_high, ptr_low, table_latch_byte;
   logic [7:0] peripheral_flags_two, peripheral_enables_two, peripheral_priority_two;
   logic [7:0] interrupt_control_main;
   logic [CW-1:0] write_count;
   logic write_target_data;
   dea_pkg::dea_key_state_t key_state, next_key_state;
   // High only until the first clock edge, so of all resets only the power-on one clears the abort flag
   logic power_on = 1'b1;

   function automatic logic hit(input dea_pkg::dea_bus_req_t r, input logic [3:0] a);
      hit = r.wr && (r.addr == a);
   endfunction

   wire logic [9:0] nv_addr = {nv_address_high[1:0], nv_address_low};
   wire logic ctl_wr = hit(bus_req, dea_pkg::ADDR_CONTROL) && !write_go;
   wire logic go_req = ctl_wr && bus_req.wdata[dea_pkg::BIT_WRITE_GO];
   // Write start accepted only with permit already stored and the key armed
   wire logic write_ok = go_req && permit && key_state == dea_pkg::DEA_KEY_ARMED;
   wire logic write_bad = go_req && !write_ok;
   wire logic read_go = ctl_wr && bus_req.wdata[dea_pkg::BIT_READ_GO] && !go_req
      && !bus_req.wdata[dea_pkg::BIT_MEM_SEL] && !bus_req.wdata[dea_pkg::BIT_CFG_SEL];
   wire logic write_done = write_go && write_count == CW'(1);

   // Unlock sequence; any other register write disarms it
   always_comb begin
      next_key_state = key_state;
      if (bus_req.wr) begin
         if (bus_req.addr == dea_pkg::ADDR_KEY) begin
            if (bus_req.wdata == dea_pkg::KEY_FIRST) begin
               next_key_state = dea_pkg::DEA_KEY_FIRST;
            end else if (bus_req.wdata == dea_pkg::KEY_SECOND && key_state == dea_pkg::DEA_KEY_FIRST) begin
               next_key_state = dea_pkg::DEA_KEY_ARMED;
            end else begin
               next_key_state = dea_pkg::DEA_KEY_IDLE;
            end
         end else begin
            next_key_state = dea_pkg::DEA_KEY_IDLE;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         key_state <= dea_pkg::DEA_KEY_IDLE;
      end else begin
         key_state <= next_key_state;
      end
   end

   // Control register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         permit <= 1'b0;
         row_erase <= 1'b0;
         write_go <= 1'b0;
      end else begin
         if (ctl_wr) begin
            permit <= bus_req.wdata[dea_pkg::BIT_PERMIT];
            row_erase <= bus_req.wdata[dea_pkg::BIT_ROW_ERASE];
         end else if (write_done) begin
            row_erase <= 1'b0;
         end
         if (write_ok) begin
            write_go <= 1'b1;
         end else if (write_done) begin
            write_go <= 1'b0;
         end
      end
   end

   // Select bits survive reset and abort alike
   always_ff @(posedge ref_clk) begin
      if (ctl_wr) begin
         mem_sel <= bus_req.wdata[dea_pkg::BIT_MEM_SEL];
         cfg_sel <= bus_req.wdata[dea_pkg::BIT_CFG_SEL];
      end
   end

   // Abort flag: armed while a write runs, so a reset mid-write leaves it set
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         power_on <= 1'b0;
         if (write_go) begin
            abort_flag <= 1'b1;
         end else if (power_on) begin
            abort_flag <= 1'b0;
         end
      end else begin
         power_on <= 1'b0;
         if (write_ok || write_bad) begin
            abort_flag <= 1'b1;
         end else if (write_done) begin
            abort_flag <= 1'b0;
         end
      end
   end

   // Self-timed counter
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         write_count <= '0;
         write_target_data <= 1'b0;
      end else if (write_ok) begin
         write_count <= CW'(WRITE_CYCLES);
         write_target_data <= !cfg_sel && !mem_sel;
      end else if (write_go) begin
         write_count <= write_count - CW'(1);
      end
   end

   // Data array: erase then program happens at the end of the timed cycle
   always_ff @(posedge ref_clk) begin
      if (write_done && write_target_data) begin
         mem[nv_addr] <= nv_data_byte;
      end
   end

   // Data and address registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         nv_data_byte <= 8'h00;
         nv_address_low <= 8'h00;
         nv_address_high <= 8'h00;
      end else begin
         if (read_go) begin
            nv_data_byte <= mem[nv_addr];
         end else if (hit(bus_req, dea_pkg::ADDR_DATA) && !write_go) begin
            nv_data_byte <= bus_req.wdata;
         end
         if (hit(bus_req, dea_pkg::ADDR_ADDR_LOW) && !write_go) begin
            nv_address_low <= bus_req.wdata;
         end
         if (hit(bus_req, dea_pkg::ADDR_ADDR_HIGH) && !write_go) begin
            nv_address_high <= bus_req.wdata;
         end
      end
   end

   // Table pointer, latch and interrupt registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ptr_upper <= 8'h00;
         ptr_high <= 8'h00;
         ptr_low <= 8'h00;
         table_latch_byte <= 8'h00;
         peripheral_enables_two <= 8'h00;
         peripheral_priority_two <= 8'h00;
         interrupt_control_main <= 8'h00;
      end else begin
         if (hit(bus_req, dea_pkg::ADDR_PTR_UPPER)) begin
            ptr_upper <= {2'b00, bus_req.wdata[5:0]};
         end
         if (hit(bus_req, dea_pkg::ADDR_PTR_HIGH)) begin
            ptr_high <= bus_req.wdata;
         end
         if (hit(bus_req, dea_pkg::ADDR_PTR_LOW)) begin
            ptr_low <= bus_req.wdata;
         end
         if (hit(bus_req, dea_pkg::ADDR_LATCH)) begin
            table_latch_byte <= bus_req.wdata;
         end
         if (hit(bus_req, dea_pkg::ADDR_ENABLES_TWO)) begin
            peripheral_enables_two <= bus_req.wdata;
         end
         if (hit(bus_req, dea_pkg::ADDR_PRIORITY_TWO)) begin
            peripheral_priority_two <= bus_req.wdata;
         end
         if (hit(bus_req, dea_pkg::ADDR_INT_MAIN)) begin
            interrupt_control_main <= bus_req.wdata;
         end
      end
   end

   // Sticky flags: write one to clear, a new completion wins
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         peripheral_flags_two <= 8'h00;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (i == dea_pkg::BIT_DONE_FLAG && write_done) begin
               peripheral_flags_two[i] <= 1'b1;
            end else if (hit(bus_req, dea_pkg::ADDR_FLAGS_TWO) && bus_req.wdata[i]) begin
               peripheral_flags_two[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(peripheral_flags_two & peripheral_enables_two);
      end
   end

   // Outward launch pulses, erase kind and table pointer toward the flash engine and configuration space
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         flash_op_start <= 1'b0;
         flash_op_erase <= 1'b0;
         cfg_op_start <= 1'b0;
         table_pointer <= '0;
      end else begin
         flash_op_start <= write_ok && mem_sel && !cfg_sel;
         cfg_op_start <= write_ok && cfg_sel;
         if (write_ok) begin
            flash_op_erase <= row_erase;
         end
         table_pointer <= {ptr_upper[5:0], ptr_high, ptr_low};
      end
   end

   // Read port, one cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rdata <= 8'h00;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            dea_pkg::ADDR_CONTROL: rdata <= {mem_sel, cfg_sel, 1'b0, row_erase, abort_flag, permit, write_go, 1'b0};
            dea_pkg::ADDR_KEY: rdata <= 8'h00;
            dea_pkg::ADDR_DATA: rdata <= nv_data_byte;
            dea_pkg::ADDR_ADDR_LOW: rdata <= nv_address_low;
            dea_pkg::ADDR_ADDR_HIGH: rdata <= nv_address_high & ~dea_pkg::UNUSED_UPPER_MASK | nv_address_high;
            dea_pkg::ADDR_PTR_UPPER: rdata <= ptr_upper;
            dea_pkg::ADDR_PTR_HIGH: rdata <= ptr_high;
            dea_pkg::ADDR_PTR_LOW: rdata <= ptr_low;
            dea_pkg::ADDR_LATCH: rdata <= table_latch_byte;
            dea_pkg::ADDR_FLAGS_TWO: rdata <= peripheral_flags_two;
            dea_pkg::ADDR_ENABLES_TWO: rdata <= peripheral_enables_two;
            dea_pkg::ADDR_PRIORITY_TWO: rdata <= peripheral_priority_two;
            dea_pkg::ADDR_INT_MAIN: rdata <= interrupt_control_main;
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule
`default_nettype wire

/* File: verification/dea_access_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module dea_access_ctrl_props #(
   parameter int WRITE_CYCLES = 10
) (
   input wire logic ref_clk, // Core clock
   input wire logic reset, // Synchronous reset
   input wire dea_pkg::dea_bus_req_t bus_req, // Register request
   input wire logic [7:0] rdata, // Read data
   input wire logic irq, // Interrupt level
   input wire logic flash_op_start, // Flash launch pulse
   input wire logic flash_op_erase, // Flash erase kind
   input wire logic cfg_op_start, // Config launch pulse
   input wire logic [21:0] table_pointer // Table pointer
);
   logic wr_low, wr_up, wr_en, ctl_go;
   assign wr_low = bus_req.wr && bus_req.addr == dea_pkg::ADDR_PTR_LOW;
   assign wr_up = bus_req.wr && bus_req.addr == dea_pkg::ADDR_PTR_UPPER;
   assign wr_en = bus_req.wr && bus_req.addr == dea_pkg::ADDR_ENABLES_TWO && bus_req.wdata == 8'h00;
   assign ctl_go = bus_req.wr && bus_req.addr == dea_pkg::ADDR_CONTROL && bus_req.wdata[1];
   // Remembers whether the most recent register write was the second key byte
   logic last_aa;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         last_aa <= 1'b0;
      end else if (bus_req.wr) begin
         last_aa <= bus_req.addr == dea_pkg::ADDR_KEY && bus_req.wdata == dea_pkg::KEY_SECOND;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence s_low_held; wr_low ##1 !wr_low; endsequence
   sequence s_up_held; wr_up ##1 !wr_up; endsequence
   property p_rd_idle; !bus_req.rd |=> rdata == 8'h00; endproperty
   property p_key_zero; bus_req.rd && bus_req.addr == dea_pkg::ADDR_KEY |=> rdata == 8'h00; endproperty
   property p_ptr_low; s_low_held |=> table_pointer[7:0] == $past(bus_req.wdata, 2); endproperty
   property p_ptr_up; s_up_held |=> table_pointer[21:16] == $past(bus_req.wdata[5:0], 2); endproperty
   property p_go_pulse; flash_op_start |=> !flash_op_start [*8]; endproperty
   property p_reset_quiet; $fell(reset) |-> !irq && !flash_op_start && !cfg_op_start; endproperty
   property p_key_order;
      ctl_go && !last_aa |=> (!flash_op_start && !cfg_op_start) [*2];
   endproperty
   property p_one_target; !(flash_op_start && cfg_op_start); endproperty
   property p_irq_mask; wr_en ##1 !wr_en |=> !irq; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
   a_key_zero: assert property (p_key_zero) else $error("key port read not zero");
   a_ptr_low: assert property (p_ptr_low) else $error("pointer low byte wrong");
   a_ptr_up: assert property (p_ptr_up) else $error("pointer upper bits wrong");
   a_go_pulse: assert property (p_go_pulse) else $error("flash launch repeated");
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
   a_key_order: assert property (p_key_order) else $error("launch without key");
   a_one_target: assert property (p_one_target) else $error("two targets at once");
   a_irq_mask: assert property (p_irq_mask) else $error("interrupt while disabled");
endmodule
bind dea_access_ctrl dea_access_ctrl_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (.ref_clk(ref_clk),
   .reset(reset), .bus_req(bus_req), .rdata(rdata), .irq(irq), .flash_op_start(flash_op_start),
   .flash_op_erase(flash_op_erase), .cfg_op_start(cfg_op_start), .table_pointer(table_pointer));
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   dea_pkg::dea_bus_req_t bus_req = '0;
   logic [7:0] rdata, v, d;
   logic irq, flash_op_start, flash_op_erase, cfg_op_start;
   logic [21:0] table_pointer, tp;
   logic [9:0] a;
   logic [7:0] pre [3] = '{8'h00, 8'h04, 8'h00};
   logic [7:0] k1 [3] = '{8'h55, 8'haa, 8'h55};
   logic [7:0] last [3] = '{8'h06, 8'h06, 8'h02};
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   int flash_n = 0;
   int cfg_n = 0;
   dea_access_ctrl #(.WRITE_CYCLES(10)) dut (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req),
      .rdata(rdata), .irq(irq), .flash_op_start(flash_op_start), .flash_op_erase(flash_op_erase),
      .cfg_op_start(cfg_op_start), .table_pointer(table_pointer));
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (flash_op_start === 1'b1) flash_n <= flash_n + 1;
      if (cfg_op_start === 1'b1) cfg_n <= cfg_n + 1;
      if (cycles == 5000) begin
         mismatches = mismatches + 1;
         report_and_stop();
      end
   end
   function automatic logic [21:0] ptr_exp(logic [7:0] u, logic [7:0] h, logic [7:0] l);
      return {u[5:0], h, l};
   endfunction
   task automatic check(string n, logic [21:0] e, logic [21:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [3:0] ad, logic [7:0] wd);
      @(posedge ref_clk);
      bus_req <= '{addr: ad, wdata: wd, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus_req <= '0;
   endtask
   task automatic rc(string n, logic [3:0] ad, logic [7:0] m, logic [7:0] e);
      @(posedge ref_clk);
      bus_req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus_req <= '0;
      #1 v = rdata;
      if (n != "") check(n, e, v & m);
   endtask
   task automatic go(logic [7:0] f, logic [7:0] s, logic [7:0] c);
      wr(dea_pkg::ADDR_KEY, f);
      wr(dea_pkg::ADDR_KEY, s);
      wr(dea_pkg::ADDR_CONTROL, c);
   endtask
   task automatic wait_done();
      for (int i = 0; i < 40; i++) begin
         rc("", dea_pkg::ADDR_CONTROL, 8'hff, 8'h00);
         if (v[1] === 1'b0) break;
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      void'($urandom(32'ha90f));
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      rc("ctl", dea_pkg::ADDR_CONTROL, 8'h3f, 8'h00);
      rc("key", dea_pkg::ADDR_KEY, 8'hff, 8'h00);
      rc("unmapped", 4'hf, 8'hff, 8'h00);
      repeat (4) begin
         tp = 22'($urandom);
         wr(dea_pkg::ADDR_PTR_UPPER, {2'($urandom), tp[21:16]});
         wr(dea_pkg::ADDR_PTR_HIGH, tp[15:8]);
         wr(dea_pkg::ADDR_PTR_LOW, tp[7:0]);
         @(posedge ref_clk);
         #1 check("pointer", ptr_exp({2'b00, tp[21:16]}, tp[15:8], tp[7:0]), table_pointer);
         rc("upper", dea_pkg::ADDR_PTR_UPPER, 8'hff, {2'b00, tp[21:16]});
      end
      wr(dea_pkg::ADDR_ENABLES_TWO, 8'h10);
      for (int i = 0; i < 2; i++) begin
         a = (i == 0) ? 10'h3ff : 10'($urandom);
         d = 8'($urandom);
         wr(dea_pkg::ADDR_ADDR_HIGH, {6'($urandom), a[9:8]});
         wr(dea_pkg::ADDR_ADDR_LOW, a[7:0]);
         wr(dea_pkg::ADDR_DATA, d);
         wr(dea_pkg::ADDR_CONTROL, 8'h04);
         go(dea_pkg::KEY_FIRST, dea_pkg::KEY_SECOND, 8'h06);
         rc("busy", dea_pkg::ADDR_CONTROL, 8'h0e, 8'h0e);
         wr(dea_pkg::ADDR_DATA, ~d);
         wr(dea_pkg::ADDR_CONTROL, 8'h00);
         wait_done();
         rc("done", dea_pkg::ADDR_CONTROL, 8'h0e, 8'h04);
         rc("flag", dea_pkg::ADDR_FLAGS_TWO, 8'h10, 8'h10);
         check("irq", 22'h1, irq);
         wr(dea_pkg::ADDR_FLAGS_TWO, 8'h10);
         @(posedge ref_clk);
         #1 check("irq clear", 22'h0, irq);
         wr(dea_pkg::ADDR_ADDR_HIGH, {6'($urandom), a[9:8]});
         wr(dea_pkg::ADDR_CONTROL, 8'h01);
         rc("data", dea_pkg::ADDR_DATA, 8'hff, d);
      end
      for (int i = 0; i < 3; i++) begin
         wr(dea_pkg::ADDR_CONTROL, pre[i]);
         go(k1[i], ~k1[i], last[i]);
         rc("refused", dea_pkg::ADDR_CONTROL, 8'h0a, 8'h08);
      end
      for (int i = 0; i < 2; i++) begin
         wr(dea_pkg::ADDR_DATA, 8'h3c);
         wr(dea_pkg::ADDR_CONTROL, (i == 0) ? 8'h81 : 8'h41);
         rc("no read", dea_pkg::ADDR_DATA, 8'hff, 8'h3c);
      end
      wr(dea_pkg::ADDR_CONTROL, 8'h94);
      go(dea_pkg::KEY_FIRST, dea_pkg::KEY_SECOND, 8'h96);
      wait_done();
      check("erase", 22'h1, flash_op_erase);
      wr(dea_pkg::ADDR_ENABLES_TWO, 8'h00);
      @(posedge ref_clk);
      #1 check("irq masked", 22'h0, irq);
      rc("row", dea_pkg::ADDR_CONTROL, 8'hd0, 8'h80);
      wr(dea_pkg::ADDR_CONTROL, 8'h44);
      go(dea_pkg::KEY_FIRST, dea_pkg::KEY_SECOND, 8'h46);
      wait_done();
      check("cfg", 22'h1, 22'(cfg_n));
      check("flash", 22'h1, 22'(flash_n));
      wr(dea_pkg::ADDR_CONTROL, 8'h84);
      go(dea_pkg::KEY_FIRST, dea_pkg::KEY_SECOND, 8'h86);
      repeat (2) @(posedge ref_clk);
      #1 check("write only", 22'h0, flash_op_erase);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      rc("abort", dea_pkg::ADDR_CONTROL, 8'hce, 8'h88);
      check("flash 2", 22'h2, 22'(flash_n));
      report_and_stop();
   end
endmodule
`default_nettype wire
